// ---- sdli_defines.vh ----
`ifndef SDLI_DEFINES_VH
`define SDLI_DEFINES_VH

`define SDLI_CODE_W      12
`define SDLI_CODE_MSB    11
`define SDLI_FULL_SCALE  12'hfff
`define SDLI_ZERO_CODE   12'h000
`define SDLI_SYNC_W      2

`endif

// ---- sdli_sync.v ----
module sdli_sync (
  input  wire clk,
  input  wire rstn,
  input  wire din,
  output reg  dout
);

  reg stage1;

  // Only the second flop may read stage1
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

// ---- sdli_load_if.v ----
`include "sdli_defines.vh"

module sdli_load_if (
  input  wire                        clk,
  input  wire                        rstn,
  input  wire                        serial_clk,
  input  wire                        serial_in,
  input  wire                        load_n,
  output reg                         serial_out,
  output reg  [`SDLI_CODE_MSB:0]     dac_code,
  output reg                         dac_full_scale,
  output reg                         dac_update
);


  // Pin order inside the synchroniser bank
  localparam PIN_SCLK = 0;
  localparam PIN_DATA = 1;
  localparam PIN_LOAD = 2;
  localparam PIN_CNT  = 3;

  // Holding register states
  localparam LS_HELD  = 2'b00;
  localparam LS_OPEN  = 2'b01;
  localparam LS_CLOSE = 2'b10;

  // Raw and synchronised pin levels
  wire [PIN_CNT-1:0]        pin_raw;
  wire [PIN_CNT-1:0]        pin_sync;
  wire                      sclk_sync;
  wire                      sin_sync;
  wire                      load_act_sync;

  // Serial clock edge finding
  reg                       sclk_prev;
  wire                      sclk_rise;

  // Shift path
  reg  [`SDLI_CODE_MSB:0]   shift_reg;
  wire [`SDLI_CODE_MSB:0]   stage_in;
  reg  [`SDLI_CODE_MSB:0]   next_shift;
  reg                       next_serial_out;

  // Holding path
  reg  [1:0]                load_state;
  reg  [1:0]                next_load_state;
  wire                      code_changed;
  reg  [`SDLI_CODE_MSB:0]   next_dac_code;
  reg                       next_full_scale;
  reg                       next_update;

  function full_scale_of;
    input [`SDLI_CODE_MSB:0] code;
    begin
      full_scale_of = (code == `SDLI_FULL_SCALE);
    end
  endfunction

  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev;
    end
  endfunction

  // Load is synchronised active high so the reset value reads as idle
  assign pin_raw[PIN_SCLK] = serial_clk;
  assign pin_raw[PIN_DATA] = serial_in;
  assign pin_raw[PIN_LOAD] = ~load_n;

  // Two flops per pin; nothing else reads the first
  genvar p;
  generate
    for (p = 0; p < PIN_CNT; p = p + 1) begin : g_pin_sync
      sdli_sync u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (pin_raw[p]),
        .dout (pin_sync[p])
      );
    end
  endgenerate

  assign sclk_sync     = pin_sync[PIN_SCLK];
  assign sin_sync      = pin_sync[PIN_DATA];
  assign load_act_sync = pin_sync[PIN_LOAD];

  // Data and clock see equal sync delay, so setup at the pin carries over
  assign sclk_rise = rise_of(sclk_sync, sclk_prev);

  // Previous level for edge finding
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_sync;
    end
  end

  // Each stage takes the one below it; stage zero takes the pin
  assign stage_in[0] = sin_sync;
  genvar b;
  generate
    for (b = 1; b <= `SDLI_CODE_MSB; b = b + 1) begin : g_stage
      assign stage_in[b] = shift_reg[b-1];
    end
  endgenerate

  always @* begin
    next_shift      = shift_reg;
    next_serial_out = serial_out;
    if (sclk_rise) begin
      next_shift      = stage_in;
      next_serial_out = stage_in[`SDLI_CODE_MSB];
    end
  end

  // Reset to zero only to keep simulation defined; value carries no meaning
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= `SDLI_ZERO_CODE;
    end else begin
      shift_reg <= next_shift;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= next_serial_out;
    end
  end

  // Close state marks the capture point; a quick reopen is still honoured
  always @* begin
    next_load_state = load_state;
    case (load_state)
      LS_HELD: begin
        if (load_act_sync) begin
          next_load_state = LS_OPEN;
        end
      end
      LS_OPEN: begin
        if (!load_act_sync) begin
          next_load_state = LS_CLOSE;
        end
      end
      LS_CLOSE: begin
        if (load_act_sync) begin
          next_load_state = LS_OPEN;
        end else begin
          next_load_state = LS_HELD;
        end
      end
      default: begin
        next_load_state = LS_HELD;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_state <= LS_HELD;
    end else begin
      load_state <= next_load_state;
    end
  end

  assign code_changed = (shift_reg != dac_code);

  // Follows the shift register while open, so late shifts still reach the output
  always @* begin
    next_dac_code   = dac_code;
    next_full_scale = dac_full_scale;
    next_update     = 1'b0;
    if (load_state == LS_OPEN) begin
      next_dac_code   = shift_reg;
      next_full_scale = full_scale_of(shift_reg);
      next_update     = code_changed;
    end
  end

  // Registered so the converter never sees a glitching code
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_code <= `SDLI_ZERO_CODE;
    end else begin
      dac_code <= next_dac_code;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_full_scale <= 1'b0;
    end else begin
      dac_full_scale <= next_full_scale;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_update <= 1'b0;
    end else begin
      dac_update <= next_update;
    end
  end

endmodule

// ---- sdli_host.sv ----
module sdli_host (
  input  wire  clk,
  output logic serial_clk,
  output logic serial_in,
  output logic load_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clk <= 1'b0;
    serial_in  <= 1'b0;
    load_n     <= 1'b1;
  end
  // Low phase of 6 or 7 cycles and high of 6 average a 125 ns period
  task automatic send(input logic [23:0] c, input int n);
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= c[i];
      repeat (6 + (i % 2)) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (6) @(posedge clk);
      serial_clk <= 1'b0;
    end
    @(posedge clk);
    serial_in <= ~c[0]; // Stale data never left on the pin
  endtask
  task automatic load;
    @(posedge clk);
    load_n <= 1'b0;
    repeat (20) @(posedge clk);
    load_n <= 1'b1;
  endtask
endmodule

// ---- sdli_load_if_monitor.sv ----
module sdli_load_if_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        serial_clk,
  input wire logic        serial_in,
  input wire logic        load_n,
  input wire logic        serial_out,
  input wire logic [11:0] dac_code,
  input wire logic        dac_full_scale,
  input wire logic        dac_update
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_fs; dac_full_scale == (dac_code == 12'hfff); endproperty
  a_fs: assert property (p_fs) else $error("full scale flag wrong");
  property p_hold; load_n [*6] |-> $stable(dac_code); endproperty
  a_hold: assert property (p_hold) else $error("code moved while latched");
  property p_upd; dac_update |-> $changed(dac_code); endproperty
  a_upd: assert property (p_upd) else $error("update without change");
  property p_so; $changed(serial_out) |-> $past(serial_clk, 3); endproperty
  a_so: assert property (p_so) else $error("serial out moved off a shift");
  property p_so_idle; !serial_clk [*6] |-> $stable(serial_out); endproperty
  a_so_idle: assert property (p_so_idle) else $error("serial out moved while idle");
  property p_upd_load; dac_update |-> !$past(load_n, 4); endproperty
  a_upd_load: assert property (p_upd_load) else $error("update with load high");
  property p_trans; (!load_n && !serial_clk) [*8] |-> $stable(dac_code); endproperty
  a_trans: assert property (p_trans) else $error("open latch did not settle");
  c_load: cover property (!load_n);
  c_upd: cover property (dac_update);
  c_so: cover property ($rose(serial_out));
endmodule
bind sdli_load_if sdli_load_if_monitor mon (
  .clk            (clk),
  .rstn           (rstn),
  .serial_clk     (serial_clk),
  .serial_in      (serial_in),
  .load_n         (load_n),
  .serial_out     (serial_out),
  .dac_code       (dac_code),
  .dac_full_scale (dac_full_scale),
  .dac_update     (dac_update)
);

// ---- sdli_load_if_tb.sv ----
module sdli_load_if_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  wire         sc;
  wire         si;
  wire         ld;
  wire         so;
  wire         so_far;
  wire         fs;
  wire         up;
  wire  [11:0] code;
  wire  [11:0] code_far;
  int          n_errors = 0;
  int          tests_run = 0;
  sdli_host h (.clk(clk), .serial_clk(sc), .serial_in(si), .load_n(ld));
  sdli_load_if uut (.clk(clk), .rstn(rstn), .serial_clk(sc), .serial_in(si), .load_n(ld),
    .serial_out(so), .dac_code(code), .dac_full_scale(fs), .dac_update(up));
  sdli_load_if uut_far (.clk(clk), .rstn(rstn), .serial_clk(sc), .serial_in(so),
    .load_n(ld), .serial_out(so_far), .dac_code(code_far), .dac_full_scale(),
    .dac_update());
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(string n, logic [11:0] s, logic [11:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_code(input logic [11:0] c);
    h.send({12'h000, c}, 12);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("serial_out", so, c[11]);
    h.load;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("dac_code", code, c);
    chk("full_scale", fs, c == 12'hfff);
  endtask
  task automatic t_hold; // Latched code must ignore new shifts
    h.send(24'h000_3c3, 12);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("held", code, 12'ha5c);
    chk("serial_out_held", so, 12'h000);
  endtask
  task automatic t_chain; // Two devices share clock and load
    h.send(24'h5a1_c3e, 24);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("near_before_load", code, 12'ha5c);
    chk("near_serial_out", so, 12'h001);
    chk("far_serial_out", so_far, 12'h000);
    h.load;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("near_code", code, 12'hc3e);
    chk("far_code", code_far, 12'h5a1);
  endtask
  task automatic t_reset; // Mid-run reset clears both registers
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("reset_code", code, 12'h000);
    chk("reset_serial_out", so, 12'h000);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_code(12'hfff);
    t_code(12'h000);
    t_code(12'ha5c);
    t_hold;
    t_chain;
    t_reset;
    t_code(12'h7f0);
    summarize;
  end
  initial begin
    #100000;
    n_errors++;
    summarize;
  end
endmodule
